//--- rtl/bvs_regs.sv
// Purpose: serial slave holding both buck setpoints and the control source bit
// Assumes: scl_i and sda_i are already synchronous to clk and debounced
// Notes:   pointer auto-increments after every data byte, read or write
//
// Function
// - Every register returns to its default at start-up.
// - Index 0x00 is the first converter setpoint and 0x01 the second.
// - After power-up each converter runs on its fused code, not its register.
// - On the externally adjusted variant the register never alters the output.
// - Bits 6 to 0 of each setpoint are a code the host can write and read back.
// - Each code resets to 0x10.
// - Code 00 means 0.825 V rising in even steps to 6F at 3.600 V.
// - Bit 6 of the system control register picks fuse (0) or register (1), reset 0.
// - Registers are reached over a serial slave at address 1101000, up to 400 kb/s.
`timescale 1ns/1ps
module bvs_regs
    import bvs_pkg::*;
(
    input  wire logic                     clk,           // 250 MHz clock
    input  wire logic                     nrst,          // async reset, active low
    input  wire logic                     scl_i,         // serial clock level
    input  wire logic                     sda_i,         // serial data level
    output logic                          sda_o,         // data drive value, always low
    output logic                          sda_oe,        // high while pulling data low
    input  wire logic                     adj_variant,   // externally adjusted part
    input  wire logic [1:0][6:0]          fuse_code,     // factory codes per converter
    output logic      [1:0][6:0]          applied_code,  // codes the converters use
    output logic                          src_reg        // register control selected
);
    import bvs_pkg::*;

    bvs_state_t       state_q;
    bvs_state_t       state_d;
    logic             scl_q;
    logic             sda_q;
    logic [3:0]       cnt_q;
    logic [3:0]       cnt_d;
    logic [7:0]       shift_q;
    logic [7:0]       shift_d;
    logic [7:0]       tx_q;
    logic [7:0]       tx_d;
    logic [7:0]       ptr_q;
    logic [7:0]       ptr_d;
    logic             rw_q;
    logic             rw_d;
    logic             oe_q;
    logic             oe_d;
    logic             mnack_q;
    logic             mnack_d;
    logic             src_q;
    logic             src_d;
    logic             start;
    logic             stop;
    logic             rise;
    logic             fall;
    logic             wr_fire;
    logic [7:0]       rd_byte;
    logic [1:0][6:0]  code;
    bvs_wr_t          wr [BVS_NUM_BUCK];

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    // data moving while the clock is high marks start and stop
    assign start = scl_q && scl_i && sda_q && !sda_i;
    assign stop  = scl_q && scl_i && !sda_q && sda_i;
    assign rise  = !scl_q && scl_i;
    assign fall  = scl_q && !scl_i;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped indices read as zero; reserved bits are zero
    always_comb begin
        unique case (ptr_q)
            BVS_IDX_BUCK1:  rd_byte = {1'b0, code[0]};
            BVS_IDX_BUCK2:  rd_byte = {1'b0, code[1]};
            BVS_IDX_SYSCTL: rd_byte = {1'b0, src_q, 6'h00};
            default:        rd_byte = BVS_UNMAPPED_RD;
        endcase
    end

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    // a data byte is committed at the falling edge after its eighth bit
    assign wr_fire = (state_q == BVS_WDATA) && fall && (cnt_q == BVS_BYTE_BITS) && !start && !stop;

    genvar g;
    generate
        for (g = 0; g < BVS_NUM_BUCK; g++) begin : g_buck
            // index of converter g is its number in the map
            assign wr[g].en   = wr_fire && (ptr_q == 8'(g));
            assign wr[g].data = shift_q[6:0];

            bvs_setpoint u_setpoint (
                .clk          (clk),
                .nrst         (nrst),
                .wr           (wr[g]),
                .src_reg      (src_q),
                .adj_variant  (adj_variant),
                .fuse_code    (fuse_code[g]),
                .code         (code[g]),
                .applied_code (applied_code[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    // open drain: a one is sent by releasing, never by driving high
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        tx_d    = tx_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        oe_d    = oe_q;
        mnack_d = mnack_q;
        src_d   = src_q;
        if (start) begin
            state_d = BVS_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop) begin
            state_d = BVS_IDLE;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                BVS_IDLE: begin
                    oe_d = 1'b0;
                end
                BVS_ADDR, BVS_REG, BVS_WDATA: begin
                    if (rise) begin
                        shift_d = {shift_q[6:0], sda_i};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (fall && cnt_q == BVS_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        if (state_q == BVS_ADDR) begin
                            // foreign addresses are ignored until the next start
                            if (shift_q[7:1] == BVS_SLAVE_ADDR) begin
                                rw_d    = shift_q[0];
                                oe_d    = 1'b1;
                                state_d = BVS_AACK;
                            end else begin
                                state_d = BVS_IDLE;
                            end
                        end else if (state_q == BVS_REG) begin
                            ptr_d   = shift_q;
                            oe_d    = 1'b1;
                            state_d = BVS_RACK;
                        end else begin
                            if (ptr_q == BVS_IDX_SYSCTL) begin
                                src_d = shift_q[BVS_SRC_BIT];
                            end
                            ptr_d   = ptr_q + 8'h01;
                            oe_d    = 1'b1;
                            state_d = BVS_WACK;
                        end
                    end
                end
                BVS_AACK: begin
                    if (fall) begin
                        if (rw_q) begin
                            // read without index resumes at the current pointer
                            oe_d    = !rd_byte[7];
                            tx_d    = {rd_byte[6:0], 1'b0};
                            ptr_d   = ptr_q + 8'h01;
                            state_d = BVS_TX;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = BVS_REG;
                        end
                    end
                end
                BVS_RACK, BVS_WACK: begin
                    if (fall) begin
                        oe_d    = 1'b0;
                        state_d = BVS_WDATA;
                    end
                end
                BVS_TX: begin
                    if (rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall) begin
                        if (cnt_q == BVS_BYTE_BITS) begin
                            cnt_d   = 4'h0;
                            oe_d    = 1'b0;
                            state_d = BVS_MACK;
                        end else begin
                            oe_d = !tx_q[7];
                            tx_d = {tx_q[6:0], 1'b0};
                        end
                    end
                end
                BVS_MACK: begin
                    if (rise) begin
                        mnack_d = sda_i;
                    end else if (fall) begin
                        if (!mnack_q) begin
                            oe_d    = !rd_byte[7];
                            tx_d    = {rd_byte[6:0], 1'b0};
                            ptr_d   = ptr_q + 8'h01;
                            state_d = BVS_TX;
                        end else begin
                            state_d = BVS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // registers of the engine; all defaults come back at start-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= BVS_IDLE;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            oe_q    <= 1'b0;
            mnack_q <= 1'b0;
            src_q   <= BVS_SRC_RST;
        end else begin
            state_q <= state_d;
            scl_q   <= scl_i;
            sda_q   <= sda_i;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            tx_q    <= tx_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            oe_q    <= oe_d;
            mnack_q <= mnack_d;
            src_q   <= src_d;
        end
    end

    assign sda_o   = 1'b0;  // constant; the line only ever pulls low
    assign sda_oe  = oe_q;
    assign src_reg = src_q;

endmodule : bvs_regs

//--- rtl/bvs_pkg.sv
// Purpose: shared constants and types of the buck setpoint register bank
// Assumes: register indices are the printed byte offsets of the serial map
// Notes:   codes are seven bits wide; bit 7 of a setpoint always reads zero
package bvs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] BVS_IDX_BUCK1   = 8'h00;
    localparam logic [7:0] BVS_IDX_BUCK2   = 8'h01;
    localparam logic [7:0] BVS_IDX_SYSCTL  = 8'h05;
    localparam logic [7:0] BVS_UNMAPPED_RD = 8'h00;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         BVS_CODE_W      = 7;
    localparam int         BVS_NUM_BUCK    = 2;
    localparam logic [6:0] BVS_CODE_RST    = 7'h10;
    localparam int         BVS_SRC_BIT     = 6;
    localparam logic       BVS_SRC_RST     = 1'b0;

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    localparam logic [6:0] BVS_SLAVE_ADDR  = 7'h68;   // 1101000
    localparam logic [3:0] BVS_BYTE_BITS   = 4'h8;

    // write strobe with its data for one setpoint
    typedef struct packed {
        logic       en;
        logic [6:0] data;
    } bvs_wr_t;

    // serial engine states, one-hot
    typedef enum logic [8:0] {
        BVS_IDLE  = 9'h001,
        BVS_ADDR  = 9'h002,
        BVS_AACK  = 9'h004,
        BVS_REG   = 9'h008,
        BVS_RACK  = 9'h010,
        BVS_WDATA = 9'h020,
        BVS_WACK  = 9'h040,
        BVS_TX    = 9'h080,
        BVS_MACK  = 9'h100
    } bvs_state_t;

endpackage : bvs_pkg

//--- rtl/bvs_setpoint.sv
// Purpose: one converter's setpoint register and applied-code selection
// Assumes: fuse code and variant strap are static after reset
// Notes:   applied code lags the register by one clock
`timescale 1ns/1ps
module bvs_setpoint
    import bvs_pkg::*;
(
    input  wire logic                  clk,          // system clock
    input  wire logic                  nrst,         // async reset, active low
    input  wire bvs_pkg::bvs_wr_t      wr,           // write strobe and code
    input  wire logic                  src_reg,      // register control selected
    input  wire logic                  adj_variant,  // externally adjusted part
    input  wire logic [6:0]            fuse_code,    // factory code
    output logic      [6:0]            code,         // register readback
    output logic      [6:0]            applied_code  // code the converter uses
);
    logic [6:0] code_q;
    logic [6:0] code_d;
    logic [6:0] appl_q;
    logic [6:0] appl_d;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // register follows writes; fuse code wins unless software took over on a standard part
    always_comb begin
        code_d = wr.en ? wr.data : code_q;
        appl_d = (src_reg && !adj_variant) ? code_q : fuse_code;
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_q <= BVS_CODE_RST;
            appl_q <= 7'h00;
        end else begin
            code_q <= code_d;
            appl_q <= appl_d;
        end
    end

    assign code         = code_q;
    assign applied_code = appl_q;

endmodule : bvs_setpoint

//--- tb/bvs_regs_sva.sv
// Purpose: port-level checks of the buck setpoint register bank
// Assumes: scl_i and sda_i are sampled on clk, as the block sees them
// Notes:   bound to every bvs_regs instance
`timescale 1ns/1ps
module bvs_regs_sva
    import bvs_pkg::*;
(
    input wire logic            clk,          // system clock
    input wire logic            nrst,         // async reset, active low
    input wire logic            scl_i,        // serial clock level
    input wire logic            sda_i,        // resolved data level
    input wire logic            sda_o,        // data drive value
    input wire logic            sda_oe,       // data pull enable
    input wire logic            adj_variant,  // externally adjusted part
    input wire logic [1:0][6:0] fuse_code,    // factory codes
    input wire logic [1:0][6:0] applied_code, // codes in force
    input wire logic            src_reg       // register control bit
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // open drain: only the enable may move
    AST_DRIVE_LOW: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    // an ack or data level, once the pull rises, stands at least four clocks
    AST_OE_STANDS: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("data pull dropped too early");
    // fuse control at release, fuse codes one clock later
    AST_RELEASE: assert property ($rose(nrst) |-> !src_reg ##1 applied_code == $past(fuse_code))
        else $error("wrong state after reset release");
    AST_FUSE_ONLY: assert property (!src_reg |=> applied_code == $past(fuse_code))
        else $error("applied code not fuse while fuse control");
    AST_ADJ_FUSE: assert property (adj_variant |=> applied_code == $past(fuse_code))
        else $error("adjustable part follows register");
    // writes land right after a falling clock, never while it is high
    AST_SRC_CLK_LOW: assert property ($changed(src_reg) |-> !scl_i)
        else $error("source bit moved with clock high");
    AST_OE_CLK_LOW: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data drive moved with clock high");
    AST_START_FREE: assert property (scl_i && $fell(sda_i) |-> !sda_oe)
        else $error("device pulled data at a start");
    AST_STOP_FREE: assert property (scl_i && $rose(sda_i) |-> !sda_oe)
        else $error("device pulling at a stop");
    // the reset step itself is excluded by the second past sample
    AST_APPLIED_QUIET: assert property ($changed(applied_code) && $past(nrst, 2) |-> !scl_i)
        else $error("applied code moved with clock high");

    // main scenarios reached
    cover property ($rose(src_reg));
    cover property ($rose(sda_oe));
    cover property (adj_variant && src_reg);
    cover property ($fell(src_reg));
endmodule : bvs_regs_sva

bind bvs_regs bvs_regs_sva i_sva (.clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .adj_variant(adj_variant), .fuse_code(fuse_code), .applied_code(applied_code),
    .src_reg(src_reg));

//--- tb/bvs_host_model.sv
// Purpose: serial bus master facing the setpoint register bank
// Assumes: pull-up on data; released data reads high on the wire
// Notes:   phases run faster than the rated ceiling to keep runs short
`timescale 1ns/1ps
module bvs_host_model #(
    parameter int QTR = 8              // clocks per quarter bit, slave needs 2
) (
    input  wire logic clk,             // system clock
    input  wire logic line,            // resolved data wire
    output logic      scl,             // serial clock drive
    output logic      sda              // data drive, 1 = released
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // one quarter bit with both lines held
    task automatic drv(input logic c, input logic d);
        scl <= c;
        sda <= d;
        repeat (QTR) @(posedge clk);
    endtask : drv

    // start or repeated start: data falls with clock high
    task automatic start();
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
        drv(1'b0, 1'b0);
    endtask : start

    // data changes only with the clock low
    task automatic bitx(input logic b, output logic r);
        drv(1'b0, sda);
        drv(1'b0, b);
        drv(1'b1, b);
        r = line;
        drv(1'b1, b);
    endtask : bitx

    // byte msb first, then the ninth bit driven as mack
    task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(mack, ack);
    endtask : xbyte

    task automatic stop();
        drv(1'b0, sda);
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
    endtask : stop
endmodule : bvs_host_model

//--- tb/tb_buck_voltage_setpoint_regs.sv
// Purpose: register access tests of the buck setpoint register bank
// Assumes: host model makes all bus traffic
// Notes:   codes above 6f never written; only the reserved bit is abused
`timescale 1ns/1ps
module tb_buck_voltage_setpoint_regs;
    import bvs_pkg::*;
    logic            clk, nrst, adj_variant, sda_oe, sda_o, src_reg, scl, sda_h, ab;
    logic [1:0][6:0] fuse_code, applied_code;
    logic [7:0]      rb;
    int              n_fail, total_checks;
    wire             sda_w = sda_h & ~sda_oe;  // pull-up wins when released

    bvs_regs i_dut (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .adj_variant(adj_variant), .fuse_code(fuse_code), .applied_code(applied_code), .src_reg(src_reg));
    bvs_host_model #(.QTR(8)) i_host (.clk(clk), .line(sda_w), .scl(scl), .sda(sda_h));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // address, index, then the low n bytes of d, highest byte first
    task automatic reg_wr(input logic [7:0] idx, input logic [15:0] d, input int n);
        logic [7:0] r;
        logic       a;
        i_host.start();
        i_host.xbyte({BVS_SLAVE_ADDR, 1'b0}, 1'b1, r, a);
        chk(16'(a), 16'h0000);
        i_host.xbyte(idx, 1'b1, r, a);
        chk(16'(a), 16'h0000);
        for (int k = n - 1; k >= 0; k--) begin
            i_host.xbyte(d[8*k +: 8], 1'b1, r, a);
            chk(16'(a), 16'h0000);
        end
        i_host.stop();
    endtask : reg_wr

    // set pointer, stop, new start, one byte read with master nack
    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        reg_wr(idx, 16'h0000, 0);
        i_host.start();
        i_host.xbyte({BVS_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
        chk(16'(a), 16'h0000);
        i_host.xbyte(8'hff, 1'b1, r, a);
        i_host.stop();
        chk({8'h00, r}, {8'h00, exp});
    endtask : reg_rd

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // a full run needs about 25k clocks
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        adj_variant = 1'b0;
        fuse_code = {7'h2a, 7'h31};
        n_fail = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk({2'b00, applied_code}, {2'b00, 7'h2a, 7'h31});
        chk(16'(src_reg), 16'h0000);
        reg_rd(BVS_IDX_BUCK1, 8'h10);
        reg_rd(BVS_IDX_BUCK2, 8'h10);
        reg_rd(BVS_IDX_SYSCTL, 8'h00);
        reg_wr(BVS_IDX_BUCK1, 16'h00ef, 1);
        reg_rd(BVS_IDX_BUCK1, 8'h6f);
        reg_wr(BVS_IDX_BUCK2, 16'h0000, 1);
        reg_rd(BVS_IDX_BUCK2, 8'h00);
        // foreign address: no ack, following bytes ignored
        i_host.start();
        i_host.xbyte({7'h69, 1'b0}, 1'b1, rb, ab);
        chk(16'(ab), 16'h0001);
        i_host.xbyte(8'h00, 1'b1, rb, ab);
        i_host.xbyte(8'h05, 1'b1, rb, ab);
        i_host.stop();
        reg_rd(BVS_IDX_BUCK1, 8'h6f);
        reg_rd(8'h03, 8'h00);
        reg_wr(BVS_IDX_BUCK1, 16'h253a, 2);
        reg_rd(BVS_IDX_BUCK1, 8'h25);
        reg_rd(BVS_IDX_BUCK2, 8'h3a);
        // two-byte read: master acks the first byte, the pointer moves on
        reg_wr(BVS_IDX_BUCK1, 16'h0000, 0);
        i_host.start();
        i_host.xbyte({BVS_SLAVE_ADDR, 1'b1}, 1'b1, rb, ab);
        chk(16'(ab), 16'h0000);
        i_host.xbyte(8'hff, 1'b0, rb, ab);
        chk({8'h00, rb}, 16'h0025);
        i_host.xbyte(8'hff, 1'b1, rb, ab);
        i_host.stop();
        chk({8'h00, rb}, 16'h003a);
        chk({2'b00, applied_code}, {2'b00, 7'h2a, 7'h31});
        reg_wr(BVS_IDX_SYSCTL, 16'h0040, 1);
        chk(16'(src_reg), 16'h0001);
        chk({2'b00, applied_code}, {2'b00, 7'h3a, 7'h25});
        reg_rd(BVS_IDX_SYSCTL, 8'h40);
        reg_wr(BVS_IDX_BUCK2, 16'h006f, 1);
        chk({2'b00, applied_code}, {2'b00, 7'h6f, 7'h25});
        // second reset as the externally adjusted part
        nrst <= 1'b0;
        adj_variant <= 1'b1;
        fuse_code <= {7'h11, 7'h5c};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(src_reg), 16'h0000);
        reg_rd(BVS_IDX_BUCK2, 8'h10);
        reg_wr(BVS_IDX_BUCK1, 16'h0033, 1);
        reg_wr(BVS_IDX_SYSCTL, 16'h0040, 1);
        chk(16'(src_reg), 16'h0001);
        chk({2'b00, applied_code}, {2'b00, 7'h11, 7'h5c});
        // handing control back to the fuses clears the source bit
        reg_wr(BVS_IDX_SYSCTL, 16'h0000, 1);
        chk(16'(src_reg), 16'h0000);
        chk({2'b00, applied_code}, {2'b00, 7'h11, 7'h5c});
        conclude();
    end
endmodule : tb_buck_voltage_setpoint_regs
